// ==== design/mct_map.svh ====
// register map, field positions, reset values and period counts of the clock controller
`ifndef MCT_MAP_SVH
`define MCT_MAP_SVH

// register indices; byte address is four times the index
`define MCT_IDX_MISC      10'h020
`define MCT_IDX_CSR       10'h029

// misc_config_one fields
`define MCT_MISC_SMS      0
`define MCT_MISC_CP_LO    1
`define MCT_MISC_CP_HI    2
`define MCT_MISC_MCO      5
`define MCT_MISC_RST      8'h00

// clock_timer_ctrl_status fields
`define MCT_CSR_FLAG      0
`define MCT_CSR_IRQEN     1
`define MCT_CSR_TB_LO     2
`define MCT_CSR_TB_HI     3
`define MCT_CSR_RST       8'h01

// period lengths in oscillator cycles per time base code
`define MCT_RTC_LEN0      32000
`define MCT_RTC_LEN1      64000
`define MCT_RTC_LEN2      160000
`define MCT_RTC_LEN3      400000
`define MCT_RTC_CNT_W     19

// axi responses
`define MCT_RESP_OKAY     2'h0
`define MCT_RESP_SLVERR   2'h2

`endif

// ==== design/mct_pkg.sv ====
// types shared by the clock controller modules
package mct_pkg;
  typedef enum logic [1:0] {
    pwr_run      = 2'b00,
    pwr_sleep    = 2'b01,
    pwr_act_halt = 2'b10,
    pwr_halt     = 2'b11
  } mct_pwr_t;
endpackage : mct_pkg

// ==== design/mct_rtc_if.sv ====
// link between controller and real time period counter
`timescale 1ns/1ps
`default_nettype none
interface mct_rtc_if;
  logic       run;
  logic [1:0] tb_sel;
  logic       period_end;
  modport ctrl (output run, output tb_sel, input period_end);
  modport cnt  (input run, input tb_sel, output period_end);
endinterface : mct_rtc_if
`default_nettype wire

// ==== design/mct_rtc_counter.sv ====
// real time period counter with deferred period length
`timescale 1ns/1ps
`default_nettype none
`include "mct_map.svh"
module mct_rtc_counter #(
  parameter int CNT_W = `MCT_RTC_CNT_W,
  parameter int LEN0  = `MCT_RTC_LEN0,
  parameter int LEN1  = `MCT_RTC_LEN1,
  parameter int LEN2  = `MCT_RTC_LEN2,
  parameter int LEN3  = `MCT_RTC_LEN3
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // controller side
  mct_rtc_if.cnt   rtc
);
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] last_q;
  logic             end_q;

  // last count of a period for a given time base code
  function automatic logic [CNT_W-1:0] last_of(input logic [1:0] sel);
    unique case (sel)
      2'b00: last_of = CNT_W'(LEN0 - 1);
      2'b01: last_of = CNT_W'(LEN1 - 1);
      2'b10: last_of = CNT_W'(LEN2 - 1);
      2'b11: last_of = CNT_W'(LEN3 - 1);
    endcase
  endfunction : last_of

  // count oscillator cycles; length is latched only at a period boundary
  // so a time base change never shifts the running period
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_q  <= '0; // [RULE_20]
      last_q <= CNT_W'(LEN0 - 1);
      end_q  <= 1'b0;
    end else begin
      end_q <= 1'b0;
      if (rtc.run) begin
        if (cnt_q == last_q) begin
          cnt_q  <= '0; // [RULE_20]
          last_q <= last_of(rtc.tb_sel); // [RULE_09]
          end_q  <= 1'b1; // [RULE_08]
        end else begin
          cnt_q <= cnt_q + CNT_W'(1); // [RULE_08]
        end
      end
    end
  end

  assign rtc.period_end = end_q;

  a_period_restart: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE_20]
    (rtc.run && cnt_q == last_q) |=> (cnt_q == '0 && end_q))
    else $error("period counter did not restart at its last count");

  a_len_deferred: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE_09]
    !(rtc.run && cnt_q == last_q) |=> $stable(last_q))
    else $error("period length changed inside a period");

  a_count_frozen: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE_14]
    !rtc.run |=> ($stable(cnt_q) && !end_q))
    else $error("period counter moved while stopped");
endmodule : mct_rtc_counter
`default_nettype wire

// ==== design/mct_clock_ctrl.sv ====
// main clock controller: cpu prescaler, clock out, real time timer, axi4-lite registers
// Function
// [RULE_01] cpu clock set by divider and select
// [RULE_02] slow mode divides by 4/8/16/32
// [RULE_03] select clear gives oscillator over two
// [RULE_04] can clock always oscillator over two
// [RULE_05] clock out pin gives oscillator over two
// [RULE_06] clock out stops in active halt
// [RULE_07] three functions work independently
// [RULE_08] timer periods of 32000 to 400000 cycles
// [RULE_09] new time base applies next period
// [RULE_10] period end sets flag, read clears
// [RULE_11] irq while flag and enable set
// [RULE_12] halt with enable enters active halt
// [RULE_13] active halt counts, registers frozen, irq wakes
// [RULE_14] full halt freezes counter and registers
// [RULE_15] timer irq never wakes full halt
// [RULE_16] sleep keeps timer, irq wakes
// [RULE_17] status bits 7:4 read zero
// [RULE_18] status resets to 01h
// [RULE_19] software avoids bit set/clear on status
// [RULE_20] counter restarts at zero, reset clears
`timescale 1ns/1ps
`default_nettype none
`include "mct_map.svh"
module mct_clock_ctrl #(
  parameter int RTC_LEN0 = `MCT_RTC_LEN0,
  parameter int RTC_LEN1 = `MCT_RTC_LEN1,
  parameter int RTC_LEN2 = `MCT_RTC_LEN2,
  parameter int RTC_LEN3 = `MCT_RTC_LEN3
) (
  // oscillator clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // axi4-lite write address and data
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // axi4-lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // axi4-lite read
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // cpu power requests
  input  wire logic        wait_req,
  input  wire logic        halt_req,
  input  wire logic        ext_wake,
  // clocks and status out
  output logic             cpu_clk,
  output logic             can_clk,
  output logic             clk_out,
  output logic             clk_out_oe_n,
  output logic             timer_irq,
  output logic [1:0]       power_state
);
  // register fields
  logic       sms_q;
  logic [1:0] cp_q;
  logic       mco_q;
  logic [1:0] tb_q;
  logic       irqen_q;
  logic       flag_q;
  // bus slave state
  logic       awready_q;
  logic       wready_q;
  logic       bvalid_q;
  logic [1:0] bresp_q;
  logic [9:0] aw_idx_q;
  logic [31:0] wdata_q;
  logic       wstrb0_q;
  logic       arready_q;
  logic       rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;
  logic       rd_csr_q;
  // clock generation
  logic [4:0] div_q;
  logic       cpu_clk_q;
  logic       can_clk_q;
  logic       clk_out_q;
  logic       oe_n_q;
  logic       irq_q;
  mct_pkg::mct_pwr_t pwr_q;

  logic       wr_fire;
  logic       rd_fire;
  logic [9:0] ar_idx;
  logic       frozen;
  logic       timer_wake;
  logic       period_end;

  mct_rtc_if rtc ();

  assign ar_idx     = s_axi_araddr[11:2];
  assign wr_fire    = !awready_q && !wready_q && !bvalid_q;
  assign rd_fire    = s_axi_arvalid && arready_q;
  assign frozen     = (pwr_q == mct_pkg::pwr_act_halt) || (pwr_q == mct_pkg::pwr_halt);
  assign timer_wake = flag_q && irqen_q;
  assign period_end = rtc.period_end;

  // counter runs in every mode but full halt
  assign rtc.run    = (pwr_q != mct_pkg::pwr_halt); // [RULE_13] [RULE_14] [RULE_16]
  assign rtc.tb_sel = tb_q;

  mct_rtc_counter #(
    .CNT_W (`MCT_RTC_CNT_W),
    .LEN0  (RTC_LEN0),
    .LEN1  (RTC_LEN1),
    .LEN2  (RTC_LEN2),
    .LEN3  (RTC_LEN3)
  ) u_rtc (
    .aclk    (aclk),
    .aresetn (aresetn),
    .rtc     (rtc)
  );

  // write address and data are taken in either order, response after both
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_q <= 1'b1;
      wready_q  <= 1'b1;
      bvalid_q  <= 1'b0;
      bresp_q   <= `MCT_RESP_OKAY;
      aw_idx_q  <= 10'h000;
      wdata_q   <= 32'h0000_0000;
      wstrb0_q  <= 1'b0;
    end else begin
      if (s_axi_awvalid && awready_q) begin
        awready_q <= 1'b0;
        aw_idx_q  <= s_axi_awaddr[11:2];
      end
      if (s_axi_wvalid && wready_q) begin
        wready_q <= 1'b0;
        wdata_q  <= s_axi_wdata;
        wstrb0_q <= s_axi_wstrb[0];
      end
      if (wr_fire) begin
        bvalid_q <= 1'b1;
        bresp_q  <= (aw_idx_q == `MCT_IDX_MISC || aw_idx_q == `MCT_IDX_CSR) ? `MCT_RESP_OKAY : `MCT_RESP_SLVERR;
      end
      if (bvalid_q && s_axi_bready) begin
        bvalid_q  <= 1'b0;
        awready_q <= 1'b1;
        wready_q  <= 1'b1;
      end
    end
  end

  // read path; data is captured at the address edge, which also clears the flag
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_q <= 1'b1;
      rvalid_q  <= 1'b0;
      rdata_q   <= 32'h0000_0000;
      rresp_q   <= `MCT_RESP_OKAY;
      rd_csr_q  <= 1'b0;
    end else begin
      if (rd_fire) begin
        arready_q <= 1'b0;
        rvalid_q  <= 1'b1;
        rd_csr_q  <= (ar_idx == `MCT_IDX_CSR);
        rresp_q   <= `MCT_RESP_OKAY;
        rdata_q   <= 32'h0000_0000;
        if (ar_idx == `MCT_IDX_MISC) begin
          rdata_q[`MCT_MISC_SMS]                   <= sms_q;
          rdata_q[`MCT_MISC_CP_HI:`MCT_MISC_CP_LO] <= cp_q;
          rdata_q[`MCT_MISC_MCO]                   <= mco_q;
        end else if (ar_idx == `MCT_IDX_CSR) begin
          // upper nibble stays zero
          rdata_q[`MCT_CSR_FLAG]                   <= flag_q; // [RULE_17]
          rdata_q[`MCT_CSR_IRQEN]                  <= irqen_q;
          rdata_q[`MCT_CSR_TB_HI:`MCT_CSR_TB_LO]   <= tb_q;
        end else begin
          rresp_q <= `MCT_RESP_SLVERR;
        end
      end
      if (rvalid_q && s_axi_rready) begin
        rvalid_q  <= 1'b0;
        arready_q <= 1'b1;
      end
    end
  end

  // software fields; writes are dropped while the registers are frozen
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sms_q   <= 1'(`MCT_MISC_RST >> `MCT_MISC_SMS);
      cp_q    <= 2'h0;
      mco_q   <= 1'b0;
      tb_q    <= 2'h0; // [RULE_18]
      irqen_q <= 1'b0; // [RULE_18]
    end else if (wr_fire && wstrb0_q && !frozen) begin // [RULE_13] [RULE_14]
      if (aw_idx_q == `MCT_IDX_MISC) begin
        sms_q <= wdata_q[`MCT_MISC_SMS];
        cp_q  <= wdata_q[`MCT_MISC_CP_HI:`MCT_MISC_CP_LO];
        mco_q <= wdata_q[`MCT_MISC_MCO];
      end else if (aw_idx_q == `MCT_IDX_CSR) begin
        tb_q    <= wdata_q[`MCT_CSR_TB_HI:`MCT_CSR_TB_LO];
        irqen_q <= wdata_q[`MCT_CSR_IRQEN];
      end
    end
  end

  // timeout flag: a period end in the clearing cycle keeps it set
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flag_q <= 1'b1; // [RULE_18]
    end else if (period_end) begin
      flag_q <= 1'b1; // [RULE_10]
    end else if (rd_fire && ar_idx == `MCT_IDX_CSR && !frozen) begin
      flag_q <= 1'b0; // [RULE_10]
    end
  end

  // interrupt request; cpu mask is applied outside
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= timer_wake; // [RULE_11]
    end
  end

  // power mode sequencing
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pwr_q <= mct_pkg::pwr_run;
    end else begin
      unique case (pwr_q)
        mct_pkg::pwr_run: begin
          if (halt_req) begin
            pwr_q <= irqen_q ? mct_pkg::pwr_act_halt : mct_pkg::pwr_halt; // [RULE_12]
          end else if (wait_req) begin
            pwr_q <= mct_pkg::pwr_sleep;
          end
        end
        mct_pkg::pwr_sleep: begin
          if (timer_wake || ext_wake) begin
            pwr_q <= mct_pkg::pwr_run; // [RULE_16]
          end
        end
        mct_pkg::pwr_act_halt: begin
          if (timer_wake || ext_wake) begin
            pwr_q <= mct_pkg::pwr_run; // [RULE_13]
          end
        end
        mct_pkg::pwr_halt: begin
          // only a wake-capable interrupt from elsewhere ends full halt
          if (ext_wake) begin
            pwr_q <= mct_pkg::pwr_run; // [RULE_14] [RULE_15]
          end
        end
      endcase
    end
  end

  // tap of the free divider for each slow speed code
  function automatic logic tap(input logic [4:0] div, input logic [1:0] code);
    unique case (code)
      2'b00: tap = div[1];
      2'b10: tap = div[2];
      2'b01: tap = div[3];
      2'b11: tap = div[4];
    endcase
  endfunction : tap

  // cpu clock; stopped in both halt modes, prescaler taps one shared divider
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_q     <= 5'h00;
      cpu_clk_q <= 1'b0;
    end else begin
      div_q <= div_q + 5'h01;
      if (frozen) begin
        cpu_clk_q <= 1'b0;
      end else if (sms_q) begin
        cpu_clk_q <= tap(div_q, cp_q); // [RULE_01] [RULE_02] [RULE_03]
      end else begin
        cpu_clk_q <= div_q[0]; // [RULE_03]
      end
    end
  end

  // can clock and clock out have their own toggles so no setting couples them
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      can_clk_q <= 1'b0;
      clk_out_q <= 1'b0;
      oe_n_q    <= 1'b1;
    end else begin
      can_clk_q <= ~can_clk_q; // [RULE_04] [RULE_07]
      oe_n_q    <= ~mco_q; // [RULE_05]
      if (mco_q && !frozen) begin
        clk_out_q <= ~clk_out_q; // [RULE_05] [RULE_07]
      end else if (!mco_q) begin
        clk_out_q <= 1'b0;
      end
      // in halt the pin holds its level: [RULE_06]
    end
  end

  assign s_axi_awready = awready_q;
  assign s_axi_wready  = wready_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;
  assign cpu_clk       = cpu_clk_q;
  assign can_clk       = can_clk_q;
  assign clk_out       = clk_out_q;
  assign clk_out_oe_n  = oe_n_q;
  assign timer_irq     = irq_q;
  assign power_state   = pwr_q;

  a_flag_set_wins: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE_10]
    period_end |=> flag_q)
    else $error("period end did not leave the flag set");

  a_read_clears: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE_10]
    (rd_fire && ar_idx == `MCT_IDX_CSR && !frozen && !period_end) |=> !flag_q)
    else $error("status read did not clear the flag");

  a_irq_follows: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE_11]
    (flag_q && irqen_q) |=> timer_irq)
    else $error("timer irq missing while flag and enable set");

  a_halt_choice: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE_12]
    (pwr_q == mct_pkg::pwr_run && halt_req) |=>
      (pwr_q == ($past(irqen_q) ? mct_pkg::pwr_act_halt : mct_pkg::pwr_halt)))
    else $error("halt entered the wrong standby mode");

  a_halt_no_timer: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE_15]
    (pwr_q == mct_pkg::pwr_halt && !ext_wake) |=> pwr_q == mct_pkg::pwr_halt)
    else $error("full halt left without an outside wake");

  a_act_halt_wake: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE_13]
    (pwr_q == mct_pkg::pwr_act_halt && timer_wake) |=> pwr_q == mct_pkg::pwr_run)
    else $error("timer irq did not end active halt");

  a_clkout_still: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE_06]
    (frozen && mco_q) |=> $stable(clk_out_q))
    else $error("clock out toggled during halt");

  a_can_toggles: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE_04]
    can_clk_q |=> !can_clk_q ##1 can_clk_q)
    else $error("can clock is not oscillator over two");

  a_normal_div: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE_03]
    (!frozen && !sms_q)[*3] |-> cpu_clk_q != $past(cpu_clk_q))
    else $error("normal mode cpu clock is not oscillator over two");

  a_csr_upper_zero: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE_17]
    (rvalid_q && rd_csr_q) |-> rdata_q[7:4] == 4'h0)
    else $error("status upper bits read nonzero");
endmodule : mct_clock_ctrl
`default_nettype wire

// ==== tb/mct_clock_ctrl_tb.sv ====
// self-checking bench for the main clock controller
`timescale 1ns/1ps
`default_nettype none
`include "mct_map.svh"
module mct_clock_ctrl_tb;
  // short periods keep the run brief; every expectation uses these
  localparam int L [4] = '{40, 60, 100, 140};
  localparam int DIV [4] = '{4, 16, 8, 32};
  localparam logic [11:0] A_MISC = 12'(4 * `MCT_IDX_MISC);
  localparam logic [11:0] A_CSR = 12'(4 * `MCT_IDX_CSR);
  localparam logic [11:0] A_BAD = A_CSR + 12'h004;
  localparam logic [1:0] OK = `MCT_RESP_OKAY;
  localparam logic [1:0] ERR = `MCT_RESP_SLVERR;

  // bus, power request and observed signals
  logic        aclk, aresetn, awv, awr, wv, wr_rdy, bv, br, arv, arr, rv, rr;
  logic [11:0] awa, ara;
  logic [31:0] wd, rdat;
  logic [3:0]  ws;
  logic [1:0]  bresp, rresp, pstate;
  logic        wreq, hreq, xwake, cpu_clk, can_clk, clk_out, oe_n, irq, co;
  logic        irq_q = 1'b0;
  int          error_cnt, cmp_count;
  int          cyc = 0, rise_cnt = 0, last_rise = 0, prev_rise = 0;

  mct_clock_ctrl #(.RTC_LEN0(L[0]), .RTC_LEN1(L[1]), .RTC_LEN2(L[2]), .RTC_LEN3(L[3])) i_dut (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv), .s_axi_wready(wr_rdy),
    .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(br),
    .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_rdata(rdat), .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rr),
    .wait_req(wreq), .halt_req(hreq), .ext_wake(xwake),
    .cpu_clk(cpu_clk), .can_clk(can_clk), .clk_out(clk_out), .clk_out_oe_n(oe_n),
    .timer_irq(irq), .power_state(pstate)
  );

  // oscillator at 25 MHz
  always #20 aclk = ~aclk;

  // cycle count and rise times of the timer request
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    irq_q <= irq;
    if (irq === 1'b1 && irq_q === 1'b0) begin
      prev_rise <= last_rise;
      last_rise <= cyc;
      rise_cnt <= rise_cnt + 1;
    end
  end

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("FAIL %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  // axi4-lite write: address and data offered together, each dropped once taken
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge aclk);
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    br <= 1'b1;
    while (n < 200) begin
      @(posedge aclk);
      n++;
      if (bv === 1'b1) break;
      if (awr === 1'b1 && awv) awv <= 1'b0;
      if (wr_rdy === 1'b1 && wv) wv <= 1'b0;
    end
    br <= 1'b0;
    chk("bresp", {29'h0, 1'b1, er}, {29'h0, bv, bresp});
  endtask : wr

  // axi4-lite read; a status read also clears the timeout flag
  task automatic rd(input logic [11:0] a, input logic [31:0] exp, input bit ck, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge aclk);
    ara <= a;
    arv <= 1'b1;
    rr <= 1'b1;
    while (n < 200) begin
      @(posedge aclk);
      n++;
      if (rv === 1'b1) break;
      if (arr === 1'b1 && arv) arv <= 1'b0;
    end
    rr <= 1'b0;
    chk("rresp", {29'h0, 1'b1, er}, {29'h0, rv, rresp});
    if (ck) chk("rdata", exp, rdat);
  endtask : rd

  // period of a clock output; the first rise is skipped, as the divider phase is free
  task automatic per(input int s, input int exp, input string nm);
    int n, k, t0;
    logic p, c;
    n = 0;
    k = 0;
    t0 = 0;
    p = 1'b1;
    while (n < 300 && k < 3) begin
      @(posedge aclk);
      n++;
      c = (s == 0) ? cpu_clk : (s == 1) ? can_clk : clk_out;
      if (c === 1'b1 && p === 1'b0) begin
        k++;
        if (k == 2) t0 = n;
      end
      p = c;
    end
    chk(nm, exp, n - t0);
  endtask : per

  // wait for the next timer request rise and optionally check the gap to the one before
  task automatic wait_rise(input int exp, input bit ck);
    int r, n;
    r = rise_cnt;
    n = 0;
    while (rise_cnt == r && n < 1000) begin
      @(posedge aclk);
      n++;
    end
    if (n >= 1000) chk("irq wait", 1, 0);
    if (ck) chk("period", exp, last_rise - prev_rise);
  endtask : wait_rise

  // one-cycle power request: 0 wait, 1 halt, 2 external wake
  task automatic pulse(input int w);
    @(posedge aclk);
    if (w == 0) wreq <= 1'b1;
    else if (w == 1) hreq <= 1'b1;
    else xwake <= 1'b1;
    @(posedge aclk);
    wreq <= 1'b0;
    hreq <= 1'b0;
    xwake <= 1'b0;
  endtask : pulse

  // enable the request on time base 00 and align to a fresh period
  task automatic sync_tb0();
    rd(A_CSR, 0, 0, OK);
    wr(A_CSR, 32'h0000_0002, OK);
    wait_rise(0, 0);
    rd(A_CSR, 0, 0, OK);
  endtask : sync_tb0

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : final_report

  // watchdog: the whole sequence needs a few thousand cycles
  initial begin
    #(40 * 20000);
    error_cnt++;
    final_report();
  end

  initial begin
    {aclk, aresetn, awv, wv, br, arv, rr, wreq, hreq, xwake} = '0;
    {awa, ara, wd} = '0;
    ws = 4'h1;
    {error_cnt, cmp_count} = '0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd(A_CSR, 32'h0000_0001, 1, OK);
    rd(A_CSR, 32'h0000_0000, 1, OK);
    rd(A_MISC, 32'h0000_0000, 1, OK);
    wr(A_CSR, 32'h0000_00F3, OK);
    rd(A_CSR, 32'h0000_0002, 1, OK);
    // every time base, each change taking effect one period late
    wait_rise(0, 0);
    for (int k = 0; k < 4; k++) begin
      wr(A_CSR, 32'(k << 2) | 32'h0000_0002, OK);
      rd(A_CSR, 32'(k << 2) | 32'h0000_0003, 1, OK);
      wait_rise(L[(k == 0) ? 0 : k - 1], 1);
      rd(A_CSR, 32'(k << 2) | 32'h0000_0003, 1, OK);
      wait_rise(L[k], 1);
    end
    // prescaler in normal and every slow code
    per(1, 2, "can_clk");
    per(0, 2, "cpu_clk");
    for (int c = 0; c < 4; c++) begin
      wr(A_MISC, 32'(c << 1) | 32'h0000_0001, OK);
      rd(A_MISC, 32'(c << 1) | 32'h0000_0001, 1, OK);
      per(0, DIV[c], "cpu_clk");
      per(1, 2, "can_clk");
    end
    wr(A_MISC, 32'h0000_00E7, OK);
    rd(A_MISC, 32'h0000_0027, 1, OK);
    chk("clk_out_oe_n", 0, oe_n);
    per(2, 2, "clk_out");
    per(0, 32, "cpu_clk");
    // active halt: counter runs, clock out frozen, timer wakes
    wr(A_MISC, 32'h0000_0020, OK);
    sync_tb0();
    pulse(1);
    @(posedge aclk);
    chk("power_state", 2, pstate);
    co = clk_out;
    repeat (4) @(posedge aclk);
    chk("clk_out", co, clk_out);
    chk("cpu_clk", 0, cpu_clk);
    wait_rise(L[0], 1);
    repeat (2) @(posedge aclk);
    chk("power_state", 0, pstate);
    // full halt: counter and registers frozen, only the external wake ends it
    wr(A_CSR, 32'h0000_0000, OK);
    rd(A_CSR, 0, 0, OK);
    pulse(1);
    @(posedge aclk);
    chk("power_state", 3, pstate);
    repeat (3 * L[0]) @(posedge aclk);
    chk("power_state", 3, pstate);
    wr(A_CSR, 32'h0000_000E, OK);
    rd(A_CSR, 32'h0000_0000, 1, OK);
    pulse(2);
    @(posedge aclk);
    chk("power_state", 0, pstate);
    // sleep: timer keeps counting and wakes
    sync_tb0();
    pulse(0);
    @(posedge aclk);
    chk("power_state", 1, pstate);
    wait_rise(L[0], 1);
    repeat (2) @(posedge aclk);
    chk("power_state", 0, pstate);
    // unmapped word and clock out switched off
    wr(A_BAD, 32'h0000_00FF, ERR);
    rd(A_BAD, 32'h0000_0000, 1, ERR);
    wr(A_MISC, 32'h0000_0000, OK);
    repeat (2) @(posedge aclk);
    chk("clk_out_oe_n", 1, oe_n);
    chk("clk_out", 0, clk_out);
    final_report();
  end
endmodule : mct_clock_ctrl_tb
`default_nettype wire
